// ### inc/phqr_pkg.sv
// Shared constants and types of the packet header quadlet register bank.
package phqr_pkg;

  localparam int          PHQR_AW          = 8;
  localparam int          PHQR_DW          = 32;
  localparam int          PHQR_NUM_HDR     = 4;

  // Byte addresses of the four header quadlet registers.
  localparam logic [7:0]  PHQR_OFF_HQ0     = 8'h38;
  localparam logic [7:0]  PHQR_OFF_HQ1     = 8'h3C;
  localparam logic [7:0]  PHQR_OFF_HQ2     = 8'h40;
  localparam logic [7:0]  PHQR_OFF_HQ3     = 8'h44;
  localparam logic [31:0] PHQR_HQ_RESET    = 32'h0000_0000;
  localparam logic [31:0] PHQR_RD_IDLE     = 32'h0000_0000;

  // Asynchronous first quadlet fields.
  localparam int          PHQR_SPEED_LSB   = 14;
  localparam int          PHQR_TLABEL_LSB  = 16;
  localparam int          PHQR_RETRY_LSB   = 22;
  localparam int          PHQR_TCODE_LSB   = 24;
  localparam int          PHQR_PRIO_LSB    = 28;
  // Second asynchronous quadlet field.
  localparam int          PHQR_TARGET_LSB  = 0;
  // Isochronous header fields.
  localparam int          PHQR_LEN_LSB     = 0;
  localparam int          PHQR_TAG_LSB     = 16;
  localparam int          PHQR_CHAN_LSB    = 18;
  localparam int          PHQR_SYNC_LSB    = 28;

  localparam logic [1:0]  PHQR_SPEED_100   = 2'h0;
  localparam logic [1:0]  PHQR_SPEED_200   = 2'h1;
  localparam logic [1:0]  PHQR_SPEED_400   = 2'h2;

  typedef enum logic [1:0] {
    PHQR_MODE_INSERT_TX = 2'b01,
    PHQR_MODE_CAPTURE   = 2'b10
  } phqr_mode_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } phqr_bus_req_type;

  typedef struct packed {
    logic        valid;
    logic [1:0]  index;
    logic [31:0] data;
  } phqr_rx_hdr_type;

  typedef struct packed {
    logic [1:0]  speed;
    logic        speed_ok;
    logic [5:0]  tlabel;
    logic [1:0]  retry_code;
    logic [3:0]  tcode;
    logic [3:0]  priority_code;
  } phqr_async_q0_type;

  // A cleared quadlet decodes to the legal 100 Mb/s code, so the registered view starts valid.
  localparam phqr_async_q0_type PHQR_ASYNC_Q0_RESET = '{speed_ok: 1'b1, default: '0};

  typedef struct packed {
    logic [15:0] data_length;
    logic [1:0]  tag;
    logic [5:0]  channel;
    logic [3:0]  tcode;
    logic [3:0]  sync_bits;
  } phqr_iso_type;

  typedef logic [PHQR_NUM_HDR-1:0][31:0]   phqr_bank_type;
  typedef phqr_iso_type [PHQR_NUM_HDR-1:0] phqr_iso_bank_type;

  typedef struct packed {
    phqr_mode_type     mode;
    phqr_bank_type     hdr;
    logic [31:0]       rdata;
    logic              wr_refused;
    phqr_async_q0_type async_q0;
    logic [15:0]       target_node_id;
    phqr_iso_bank_type iso;
  } phqr_state_type;

endpackage : phqr_pkg

// ### design/phqr_addr_decode.sv
// Address decoder that maps a byte address onto one of the header quadlets.
module phqr_addr_decode
  import phqr_pkg::*;
(
  input  wire logic [7:0] addr_i,
  output logic            hit_o,
  output logic [1:0]      index_o
);

  always_comb begin
    hit_o   = 1'b0;
    index_o = 2'h0;
    case (addr_i)
      PHQR_OFF_HQ0: begin
        hit_o   = 1'b1;
        index_o = 2'h0;
      end
      PHQR_OFF_HQ1: begin
        hit_o   = 1'b1;
        index_o = 2'h1;
      end
      PHQR_OFF_HQ2: begin
        hit_o   = 1'b1;
        index_o = 2'h2;
      end
      PHQR_OFF_HQ3: begin
        hit_o   = 1'b1;
        index_o = 2'h3;
      end
      default: begin
        hit_o   = 1'b0;
        index_o = 2'h0;
      end
    endcase
  end

endmodule : phqr_addr_decode

// ### design/phqr_quad_decode.sv
// Field splitter for one header quadlet, in both asynchronous and isochronous layout.
module phqr_quad_decode
  import phqr_pkg::*;
(
  input  wire logic [31:0]       quadlet_i,
  input  wire logic              backplane_phy_i,
  output phqr_async_q0_type      async_o,
  output phqr_iso_type           iso_o
);

  always_comb begin
    async_o.speed         = quadlet_i[PHQR_SPEED_LSB +: 2];
    // The top code has no rate assigned, so the mover must not use it.
    async_o.speed_ok      = (quadlet_i[PHQR_SPEED_LSB +: 2] == PHQR_SPEED_100) ||
                            (quadlet_i[PHQR_SPEED_LSB +: 2] == PHQR_SPEED_200) ||
                            (quadlet_i[PHQR_SPEED_LSB +: 2] == PHQR_SPEED_400);
    async_o.tlabel        = quadlet_i[PHQR_TLABEL_LSB +: 6];
    async_o.retry_code    = quadlet_i[PHQR_RETRY_LSB +: 2];
    async_o.tcode         = quadlet_i[PHQR_TCODE_LSB +: 4];
    // Without a backplane physical layer the priority carries no meaning.
    async_o.priority_code = backplane_phy_i ? quadlet_i[PHQR_PRIO_LSB +: 4] : 4'h0;
    iso_o.data_length     = quadlet_i[PHQR_LEN_LSB +: 16];
    iso_o.tag             = quadlet_i[PHQR_TAG_LSB +: 2];
    iso_o.channel         = quadlet_i[PHQR_CHAN_LSB +: 6];
    iso_o.tcode           = quadlet_i[PHQR_TCODE_LSB +: 4];
    iso_o.sync_bits       = quadlet_i[PHQR_SYNC_LSB +: 4];
  end

endmodule : phqr_quad_decode

// ### design/phqr_regs.sv
// Header quadlet register bank of the link data mover, with decoded header fields.
module phqr_regs
  import phqr_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                reset_n_i,
  input  wire phqr_pkg::phqr_bus_req_type bus_i,
  input  wire phqr_pkg::phqr_rx_hdr_type  rx_hdr_i,
  input  wire logic                mover_header_mode_select_i,
  input  wire logic                mover_receive_select_i,
  input  wire logic                backplane_phy_i,
  output logic [31:0]              rd_data_o,
  output logic                     wr_refused_o,
  output logic                     insert_tx_o,
  output phqr_pkg::phqr_bank_type  hdr_o,
  output phqr_pkg::phqr_async_q0_type async_q0_o,
  output logic [15:0]              target_node_id_o,
  output phqr_pkg::phqr_iso_bank_type iso_hdr_o
);

  import phqr_pkg::*;

  phqr_state_type    s_q;
  phqr_state_type    s_d;
  logic              bus_hit;
  logic [1:0]        bus_idx;
  logic              insert_tx;
  phqr_async_q0_type async_dec [PHQR_NUM_HDR];
  phqr_iso_type      iso_dec   [PHQR_NUM_HDR];

  // The bank is addressed by a two-bit index; other sizes need a new decoder.
  initial begin
    if (PHQR_NUM_HDR != 4) begin
      $error("phqr_regs serves exactly four header quadlets");
    end
  end

  phqr_addr_decode u_addr_decode (
    .addr_i  (bus_i.addr),
    .hit_o   (bus_hit),
    .index_o (bus_idx)
  );

  // Every quadlet is split in both layouts, since quadlets 1 to 3 may carry
  // isochronous headers of later packets in the same cycle.
  for (genvar g = 0; g < PHQR_NUM_HDR; g++) begin : g_decode
    phqr_quad_decode u_quad_decode (
      .quadlet_i       (s_q.hdr[g]),
      .backplane_phy_i (backplane_phy_i),
      .async_o         (async_dec[g]),
      .iso_o           (iso_dec[g])
    );
  end

  // Software ownership needs insert mode and transmit direction together.
  assign insert_tx = !mover_header_mode_select_i && !mover_receive_select_i;

  always_comb begin
    s_d            = s_q;
    s_d.mode       = insert_tx ? PHQR_MODE_INSERT_TX : PHQR_MODE_CAPTURE;
    s_d.wr_refused = 1'b0;
    s_d.rdata      = PHQR_RD_IDLE;

    // Writes and captures never meet: the mode decides who owns the bank.
    if (bus_i.wr && bus_hit) begin
      if (insert_tx) begin
        s_d.hdr[bus_idx] = bus_i.wdata;
      end else begin
        s_d.wr_refused = 1'b1;
      end
    end

    if (rx_hdr_i.valid && !insert_tx) begin
      s_d.hdr[rx_hdr_i.index] = rx_hdr_i.data;
    end

    // Reads return the value before any write of the same cycle.
    if (bus_i.rd && bus_hit) begin
      s_d.rdata = s_q.hdr[bus_idx];
    end

    s_d.async_q0       = async_dec[0];
    s_d.target_node_id = s_q.hdr[1][PHQR_TARGET_LSB +: 16];
    for (int i = 0; i < PHQR_NUM_HDR; i++) begin
      s_d.iso[i] = iso_dec[i];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q.mode           <= PHQR_MODE_INSERT_TX;
      s_q.hdr            <= {PHQR_NUM_HDR{PHQR_HQ_RESET}};
      s_q.rdata          <= PHQR_RD_IDLE;
      s_q.wr_refused     <= 1'b0;
      s_q.async_q0       <= PHQR_ASYNC_Q0_RESET;
      s_q.target_node_id <= 16'h0000;
      s_q.iso            <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o        = s_q.rdata;
  assign wr_refused_o     = s_q.wr_refused;
  assign insert_tx_o      = (s_q.mode == PHQR_MODE_INSERT_TX);
  assign hdr_o            = s_q.hdr;
  assign async_q0_o       = s_q.async_q0;
  assign target_node_id_o = s_q.target_node_id;
  assign iso_hdr_o        = s_q.iso;

  default clocking cb_sys @(posedge clk_sys_i);
  endclocking

  default disable iff (!reset_n_i);

  sequence seq_owned_write;
    bus_i.wr && bus_hit && insert_tx;
  endsequence

  sequence seq_locked_write;
    bus_i.wr && bus_hit && !insert_tx && !rx_hdr_i.valid;
  endsequence

  sequence seq_capture;
    rx_hdr_i.valid && !insert_tx;
  endsequence

  sequence seq_readback;
    bus_i.rd && bus_hit && !bus_i.wr;
  endsequence

  // A write that software owns lands whole in the addressed quadlet.
  AST_WRITE_TAKES: assert property (
    seq_owned_write |=> (hdr_o[$past(bus_idx)] == $past(bus_i.wdata))
  ) else $error("Owned header write was not stored.");

  // A protected write leaves the whole bank as it was and flags itself.
  AST_WRITE_DROPPED: assert property (
    seq_locked_write |=> (hdr_o == $past(hdr_o)) && wr_refused_o
  ) else $error("Protected header write changed the bank.");

  AST_REFUSED_ONLY_ON_LOCK: assert property (
    !(bus_i.wr && bus_hit && !insert_tx) |=> !wr_refused_o
  ) else $error("Write refusal flagged without a protected write.");

  AST_CAPTURE_STORES: assert property (
    seq_capture |=> (hdr_o[$past(rx_hdr_i.index)] == $past(rx_hdr_i.data))
  ) else $error("Received header quadlet was not captured.");

  // In insert-transmit mode the link must not disturb what software loaded.
  AST_CAPTURE_BLOCKED: assert property (
    (rx_hdr_i.valid && insert_tx && !bus_i.wr) |=> (hdr_o == $past(hdr_o))
  ) else $error("Received header overwrote software header in insert mode.");

  AST_READ_DATA: assert property (
    (bus_i.rd && bus_hit) |=> (rd_data_o == $past(hdr_o[bus_idx]))
  ) else $error("Read data does not match the addressed quadlet.");

  AST_READ_IDLE_ZERO: assert property (
    !(bus_i.rd && bus_hit) |=> (rd_data_o == PHQR_RD_IDLE)
  ) else $error("Read data not zero outside a mapped read.");

  // Write then read of the same quadlet returns the written word.
  AST_WRITE_READBACK: assert property (
    seq_owned_write ##1 (seq_readback and (bus_idx == $past(bus_idx)) and !rx_hdr_i.valid)
      |=> (rd_data_o == $past(bus_i.wdata, 2))
  ) else $error("Read after owned write returned a stale value.");

  AST_SPEED_FIELD: assert property (
    1'b1 |=> (async_q0_o.speed == $past(hdr_o[0][PHQR_SPEED_LSB +: 2])) &&
             (async_q0_o.speed_ok == ($past(hdr_o[0][PHQR_SPEED_LSB +: 2]) != 2'h3))
  ) else $error("Speed field or its validity decoded wrongly.");

  AST_LABEL_RETRY_TCODE: assert property (
    1'b1 |=> (async_q0_o.tlabel == $past(hdr_o[0][PHQR_TLABEL_LSB +: 6])) &&
             (async_q0_o.retry_code == $past(hdr_o[0][PHQR_RETRY_LSB +: 2])) &&
             (async_q0_o.tcode == $past(hdr_o[0][PHQR_TCODE_LSB +: 4]))
  ) else $error("Label, retry code or transaction code decoded wrongly.");

  AST_PRIORITY_GATED: assert property (
    1'b1 |=> (async_q0_o.priority_code ==
              ($past(backplane_phy_i) ? $past(hdr_o[0][PHQR_PRIO_LSB +: 4]) : 4'h0))
  ) else $error("Priority shown without a backplane physical layer.");

  AST_TARGET_NODE: assert property (
    1'b1 |=> (target_node_id_o == $past(hdr_o[1][PHQR_TARGET_LSB +: 16]))
  ) else $error("Target node identifier does not follow quadlet 1.");

  AST_ISO_LAYOUT: assert property (
    1'b1 |=> (iso_hdr_o[2].channel == $past(hdr_o[2][PHQR_CHAN_LSB +: 6])) &&
             (iso_hdr_o[3].data_length == $past(hdr_o[3][PHQR_LEN_LSB +: 16])) &&
             (iso_hdr_o[1].tag == $past(hdr_o[1][PHQR_TAG_LSB +: 2]))
  ) else $error("Isochronous fields of a later quadlet decoded wrongly.");

  AST_MODE_FOLLOWS: assert property (
    1'b1 |=> (insert_tx_o == $past(insert_tx))
  ) else $error("Insert mode indication does not follow the selects.");

endmodule : phqr_regs

// ### test/phqr_link_model.sv
// Link-side model that hands received header quadlets to the register bank.
module phqr_link_model
  import phqr_pkg::*;
(
  input  wire logic                   clk_sys_i,
  output phqr_pkg::phqr_rx_hdr_type   rx_hdr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rx_hdr_o = '0;

  // One quadlet per strobe; afterwards the lines carry the inverse so a stale capture cannot pass.
  task automatic send(input logic [1:0] idx, input logic [31:0] data);
    @(posedge clk_sys_i);
    rx_hdr_o <= '{valid: 1'b1, index: idx, data: data};
    @(posedge clk_sys_i);
    rx_hdr_o <= '{valid: 1'b0, index: ~idx, data: ~data};
  endtask : send
endmodule : phqr_link_model

// ### test/phqr_regs_tb_top.sv
// Self-checking testbench of the header quadlet register bank.
module phqr_regs_tb_top;
  import phqr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys_i;
  logic              reset_n_i;
  logic              hdr_sel;
  logic              rx_sel;
  logic              bp_phy;
  phqr_bus_req_type  bus;
  phqr_rx_hdr_type   rx_hdr;
  logic [31:0]       rd_data;
  logic              wr_refused;
  logic              insert_tx;
  phqr_bank_type     hdr;
  phqr_async_q0_type aq0;
  logic [15:0]       target_id;
  phqr_iso_bank_type iso;
  int                fails;
  int                compares;
  logic [7:0]        offs [4];
  logic [31:0]       q0;

  phqr_regs dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_i(bus), .rx_hdr_i(rx_hdr),
    .mover_header_mode_select_i(hdr_sel), .mover_receive_select_i(rx_sel), .backplane_phy_i(bp_phy),
    .rd_data_o(rd_data), .wr_refused_o(wr_refused), .insert_tx_o(insert_tx), .hdr_o(hdr),
    .async_q0_o(aq0), .target_node_id_o(target_id), .iso_hdr_o(iso));

  phqr_link_model link_u (.clk_sys_i(clk_sys_i), .rx_hdr_o(rx_hdr));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic refused);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
    #1 chk("wr_refused_o", {31'h0, refused}, {31'h0, wr_refused});
  endtask : bus_wr

  // Read data is only looked at in the one cycle it stands, then must fall back to idle.
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    #1 chk("rd_data_o", exp, rd_data);
    @(posedge clk_sys_i);
    #1 chk("rd_data_o idle", PHQR_RD_IDLE, rd_data);
  endtask : bus_rd

  task automatic t_reset();
    #1 chk("insert_tx_o", 32'h1, {31'h0, insert_tx});
    for (int i = 0; i < 4; i++) begin
      chk("hdr_o", PHQR_HQ_RESET, hdr[i]);
      bus_rd(offs[i], PHQR_HQ_RESET);
    end
  endtask : t_reset

  task automatic t_load();
    q0 = {4'hC, 4'h5, 2'h3, 6'h2A, PHQR_SPEED_200, 14'h0};
    @(posedge clk_sys_i);
    bp_phy <= 1'b1;
    bus_wr(PHQR_OFF_HQ1, 32'hABCD_5678, 1'b0);
    bus_wr(PHQR_OFF_HQ2, 32'h9A56_1234, 1'b0);
    bus_wr(PHQR_OFF_HQ3, 32'hFFFF_0001, 1'b0);
    bus_wr(PHQR_OFF_HQ0, q0, 1'b0);
    chk("hdr_o q0", q0, hdr[0]);
    bus_rd(PHQR_OFF_HQ1, 32'hABCD_5678);
    bus_rd(PHQR_OFF_HQ2, 32'h9A56_1234);
    bus_rd(PHQR_OFF_HQ3, 32'hFFFF_0001);
    bus_rd(PHQR_OFF_HQ0, q0);
    chk("speed", {30'h0, PHQR_SPEED_200}, {30'h0, aq0.speed});
    chk("tlabel", 32'h2A, {26'h0, aq0.tlabel});
    chk("retry_code", 32'h3, {30'h0, aq0.retry_code});
    chk("tcode", 32'h5, {28'h0, aq0.tcode});
    chk("priority_code", 32'hC, {28'h0, aq0.priority_code});
    chk("target_node_id_o", 32'h5678, {16'h0, target_id});
    chk("iso length", 32'h1234, {16'h0, iso[2].data_length});
    chk("iso tag", 32'h2, {30'h0, iso[2].tag});
    chk("iso channel", 32'h15, {26'h0, iso[2].channel});
    chk("iso tcode", 32'hA, {28'h0, iso[2].tcode});
    chk("iso sync", 32'h9, {28'h0, iso[2].sync_bits});
    @(posedge clk_sys_i);
    bp_phy <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("priority_code off", 32'h0, {28'h0, aq0.priority_code});
    for (int s = 0; s < 4; s++) begin
      bus_wr(PHQR_OFF_HQ0, {16'h0, s[1:0], 14'h0}, 1'b0);
      @(posedge clk_sys_i);
      #1 chk("speed", s, {30'h0, aq0.speed});
      chk("speed_ok", {31'h0, s != 3}, {31'h0, aq0.speed_ok});
    end
  endtask : t_load

  // Each non-insert mode must refuse software writes and accept link captures instead.
  task automatic t_protect();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys_i);
      hdr_sel <= (k != 1);
      rx_sel <= (k != 0);
      bus_wr(PHQR_OFF_HQ2, 32'h0BAD_0BAD, 1'b1);
      bus_rd(PHQR_OFF_HQ2, 32'h9A56_1234);
      chk("insert_tx_o", 32'h0, {31'h0, insert_tx});
      link_u.send(k[1:0], 32'hC0DE_0000 + k);
      #1 chk("hdr_o capture", 32'hC0DE_0000 + k, hdr[k]);
      bus_rd(offs[k], 32'hC0DE_0000 + k);
    end
    @(posedge clk_sys_i);
    hdr_sel <= 1'b0;
    rx_sel <= 1'b0;
    link_u.send(2'h3, 32'h1111_1111);
    #1 chk("hdr_o ignored capture", 32'hFFFF_0001, hdr[3]);
    bus_wr(8'h30, 32'h5555_5555, 1'b0);
    bus_rd(8'h48, PHQR_RD_IDLE);
  endtask : t_protect

  // A read may follow a write with no idle cycle and must already see the new word.
  task automatic t_back_to_back();
    @(posedge clk_sys_i);
    bus <= '{addr: PHQR_OFF_HQ1, wdata: 32'h1357_9BDF, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus <= '{addr: PHQR_OFF_HQ1, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    #1 chk("rd_data_o back to back", 32'h1357_9BDF, rd_data);
  endtask : t_back_to_back

  // A reset in mid-run must clear every quadlet again, whatever was loaded before.
  task automatic t_reset_again();
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1 chk("hdr_o q1 after reset", PHQR_HQ_RESET, hdr[1]);
    chk("hdr_o q3 after reset", PHQR_HQ_RESET, hdr[3]);
    bus_rd(PHQR_OFF_HQ0, PHQR_HQ_RESET);
    bus_rd(PHQR_OFF_HQ2, PHQR_HQ_RESET);
  endtask : t_reset_again

  task automatic summarize();
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    offs = '{PHQR_OFF_HQ0, PHQR_OFF_HQ1, PHQR_OFF_HQ2, PHQR_OFF_HQ3};
    fails = 0;
    compares = 0;
    reset_n_i = 1'b0;
    hdr_sel = 1'b0;
    rx_sel = 1'b0;
    bp_phy = 1'b0;
    bus = '0;
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_load();
    t_protect();
    t_back_to_back();
    t_reset_again();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    fails++;
    summarize();
  end
endmodule : phqr_regs_tb_top
